/* File: logic/fmrd_pkg.sv */
// Shared constants for the flow meter fieldbus readout block
package fmrd_pkg;
    // Measurement register addresses, 16-bit word index
    localparam logic [15:0] REG_PRESSURE = 16'h0002;
    localparam logic [15:0] REG_FLOW = 16'h0006;
    localparam logic [15:0] REG_CONSUMPTION = 16'h0008;
    // Secondary link value register addresses
    localparam logic [7:0] MB_ADDR_CONSUMPTION = 8'h01;
    localparam logic [7:0] MB_ADDR_FLOW = 8'h02;
    localparam logic [7:0] MB_ADDR_STATUS = 8'h03;
    localparam logic [7:0] MB_PRIMARY_ADDR = 8'h01;
    // Register read function code
    localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FUNC_EXCEPTION = 8'h83;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    // Clock and link timing
    localparam int CLK_HZ = 20000000;
    localparam int MB_BAUD = 2400;
    localparam int MB_BIT_CYCLES = CLK_HZ / MB_BAUD;
    localparam int RESP_DELAY_MS = 7;
    localparam int RESP_TIMEOUT_MS = 100;
    localparam int RECV_TIMEOUT_MS = 500;
    localparam int RESP_DELAY_CYC = (CLK_HZ / 1000) * RESP_DELAY_MS;
    localparam int RESP_TIMEOUT_CYC = (CLK_HZ / 1000) * RESP_TIMEOUT_MS;
    localparam int RECV_TIMEOUT_CYC = (CLK_HZ / 1000) * RECV_TIMEOUT_MS;
    // Logger geometry
    localparam int LOG_ENTRIES = 5600000;
    localparam int LOG_AW = 23;
    localparam int LOG_DW = 128;
    // Reset values
    localparam logic LOG_EN_RST = 1'b0;
endpackage

/* File: logic/fmrd_logger.sv */
// Circular measurement logger with timestamped records
`timescale 1ns/1ps
`default_nettype none
module fmrd_logger #(
    parameter int DEPTH = fmrd_pkg::LOG_ENTRIES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Control
    input wire logic log_enable,
    input wire logic sample_tick,
    // Sampled values
    input wire logic [31:0] timestamp,
    input wire logic [31:0] flow,
    input wire logic [31:0] consumption,
    input wire logic [31:0] pressure,
    // Record write port towards storage
    output logic rec_we,
    output logic [fmrd_pkg::LOG_AW-1:0] rec_addr,
    output logic [fmrd_pkg::LOG_DW-1:0] rec_data,
    output logic [fmrd_pkg::LOG_AW-1:0] rec_count
);
    localparam logic [fmrd_pkg::LOG_AW-1:0] LAST = fmrd_pkg::LOG_AW'(DEPTH - 1);
    localparam logic [fmrd_pkg::LOG_AW-1:0] FULL = fmrd_pkg::LOG_AW'(DEPTH);
    logic [fmrd_pkg::LOG_AW-1:0] wptr_ff;
    logic [fmrd_pkg::LOG_AW-1:0] nxt_wptr;
    logic [fmrd_pkg::LOG_AW-1:0] nxt_count;
    logic take;

    // Record only while enabled; storage is external flash
    assign take = log_enable & sample_tick;
    // Wrap onto the oldest record once full
    assign nxt_wptr = (wptr_ff == LAST) ? '0 : wptr_ff + 1'b1;
    assign nxt_count = (rec_count == FULL) ? rec_count : rec_count + 1'b1;

    // Pointer, count and record register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wptr_ff <= '0;
            rec_count <= '0;
            rec_we <= 1'b0;
            rec_addr <= '0;
            rec_data <= '0;
        end else begin
            rec_we <= take;
            if (take) begin
                rec_addr <= wptr_ff;
                rec_data <= {timestamp, flow, consumption, pressure};
                wptr_ff <= nxt_wptr;
                rec_count <= nxt_count;
            end
        end
    end

    // Idle logger never strobes storage
    property p_log_gate;
        @(posedge clock) disable iff (!rst_b)
        !take |=> !rec_we;
    endproperty
    a_log_gate: assert property (p_log_gate) else $error("record while idle");
    // Each record carries the stamp of its sample
    property p_log_rec;
        @(posedge clock) disable iff (!rst_b)
        take |=> rec_data[127:96] == $past(timestamp);
    endproperty
    a_log_rec: assert property (p_log_rec) else $error("record lacks stamp");
    // Oldest slot reused once the ring is full
    property p_log_wrap;
        @(posedge clock) disable iff (!rst_b)
        (take && wptr_ff == LAST) |=> wptr_ff == '0;
    endproperty
    a_log_wrap: assert property (p_log_wrap) else $error("pointer did not wrap");
endmodule
`default_nettype wire

/* File: logic/fmrd_top.sv */
// Flow meter readout: register bank, link timing and logger
// Operation
// - Pressure at 2, flow 6, consumption 8
// - Secondary link 2400 baud, primary address 1
// - Wait 7 ms before answering
// - Response timeout 100 ms, receive 500 ms
// - Value registers consumption 1, flow 2, status 3
// - Logger idle during reset, then records while log_enable input is high
// - Record holds timestamp, flow, consumption and pressure; link status is not logged
// - Full log overwrites oldest record
// - Read answers carry function code 03, or 83 alone on error
// - Words sent byte1 byte0 byte3 byte2
`timescale 1ns/1ps
`default_nettype none
module fmrd_top #(
    parameter int RESP_DELAY = fmrd_pkg::RESP_DELAY_CYC,
    parameter int RESP_TIMEOUT = fmrd_pkg::RESP_TIMEOUT_CYC,
    parameter int RECV_TIMEOUT = fmrd_pkg::RECV_TIMEOUT_CYC,
    parameter int LOG_DEPTH = fmrd_pkg::LOG_ENTRIES,
    parameter logic [31:0] SERIAL_BCD = 32'h0000_0000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Measurement sources
    input wire logic [31:0] flow_in,
    input wire logic [31:0] consumption_in,
    input wire logic [31:0] pressure_in,
    input wire logic [31:0] link_status_in,
    input wire logic [31:0] timestamp_in,
    // Register read request, decoded frame from serial engine
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0] rd_count,
    output logic rd_busy,
    // Response byte stream
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready,
    // Secondary link request, decoded
    input wire logic mb_req,
    input wire logic [7:0] mb_primary,
    input wire logic [31:0] mb_secondary,
    input wire logic [7:0] mb_value_addr,
    input wire logic mb_rx_active,
    output logic mb_resp_valid,
    output logic [31:0] mb_resp_data,
    output logic mb_resp_timeout,
    output logic mb_rx_abort,
    output logic mb_bit_tick,
    // Logger control and storage port
    input wire logic log_enable,
    input wire logic sample_tick,
    output logic rec_we,
    output logic [fmrd_pkg::LOG_AW-1:0] rec_addr,
    output logic [fmrd_pkg::LOG_DW-1:0] rec_data,
    output logic [fmrd_pkg::LOG_AW-1:0] rec_count
);
    typedef enum logic [3:0] {
        FMRD_IDLE = 4'b0001,
        FMRD_HEAD = 4'b0010,
        FMRD_DATA = 4'b0100,
        FMRD_WAIT = 4'b1000
    } fmrd_state_t;

    // Word fetch for read-only measurement map, two words per channel
    function automatic logic [16:0] fmrd_word(input logic [15:0] a, input logic [31:0] f,
                                              input logic [31:0] c, input logic [31:0] p);
        logic [16:0] r;
        r = 17'h00000;
        case (a)
            fmrd_pkg::REG_PRESSURE: r = {1'b1, p[15:0]};
            fmrd_pkg::REG_PRESSURE + 16'h0001: r = {1'b1, p[31:16]};
            fmrd_pkg::REG_FLOW: r = {1'b1, f[15:0]};
            fmrd_pkg::REG_FLOW + 16'h0001: r = {1'b1, f[31:16]};
            fmrd_pkg::REG_CONSUMPTION: r = {1'b1, c[15:0]};
            fmrd_pkg::REG_CONSUMPTION + 16'h0001: r = {1'b1, c[31:16]};
            default: r = 17'h00000;
        endcase
        return r;
    endfunction

    fmrd_state_t state_ff, nxt_state;
    logic [15:0] addr_ff;
    logic [7:0] left_ff;
    logic hi_ff;
    logic [7:0] hdr_ff;
    logic err_ff;
    logic [16:0] cur_word;
    logic addr_ok;
    logic tx_fire;

    // Snapshot for atomic multi-byte reads
    logic [31:0] snap_f_ff, snap_c_ff, snap_p_ff;

    assign cur_word = fmrd_word(addr_ff, snap_f_ff, snap_c_ff, snap_p_ff);
    assign addr_ok = fmrd_word(rd_addr, flow_in, consumption_in, pressure_in) >> 16 != 17'h0;
    assign tx_fire = tx_valid & tx_ready;
    assign rd_busy = state_ff != FMRD_IDLE;

    // Response: function code 03 then data, or function code 83 alone on error
    // Low word goes first so a float reads byte1 byte0 byte3 byte2
    assign tx_valid = (state_ff == FMRD_HEAD) | (state_ff == FMRD_DATA);
    assign tx_byte = (state_ff == FMRD_HEAD) ? hdr_ff
                   : (hi_ff ? cur_word[7:0] : cur_word[15:8]);
    assign tx_last = (state_ff == FMRD_DATA) & hi_ff & (left_ff == 8'h01);

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FMRD_IDLE: if (rd_req) nxt_state = FMRD_HEAD;
            FMRD_HEAD: if (tx_fire) nxt_state = FMRD_WAIT;
            FMRD_WAIT: nxt_state = err_ff ? FMRD_IDLE : FMRD_DATA;
            FMRD_DATA: if (tx_fire && tx_last) nxt_state = FMRD_IDLE;
            default: nxt_state = FMRD_IDLE;
        endcase
    end

    // Read sequencer; header is the single function code byte, 03 or 83 on error
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= FMRD_IDLE;
            addr_ff <= 16'h0000;
            left_ff <= 8'h00;
            hi_ff <= 1'b0;
            hdr_ff <= 8'h00;
            err_ff <= 1'b0;
            snap_f_ff <= 32'h0000_0000;
            snap_c_ff <= 32'h0000_0000;
            snap_p_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == FMRD_IDLE && rd_req) begin
                addr_ff <= rd_addr;
                left_ff <= rd_count;
                hi_ff <= 1'b0;
                err_ff <= !addr_ok || rd_count == 8'h00;
                hdr_ff <= (addr_ok && rd_count != 8'h00) ? fmrd_pkg::FUNC_READ_HOLDING
                                                         : fmrd_pkg::FUNC_EXCEPTION;
                snap_f_ff <= flow_in;
                snap_c_ff <= consumption_in;
                snap_p_ff <= pressure_in;
            end else if (state_ff == FMRD_DATA && tx_fire) begin
                hi_ff <= !hi_ff;
                if (hi_ff) begin
                    addr_ff <= addr_ff + 16'h0001;
                    left_ff <= left_ff - 8'h01;
                end
            end
        end
    end

    // Secondary link timing
    logic [31:0] dly_ff;
    logic [31:0] tmo_ff;
    logic [31:0] rxt_ff;
    logic pend_ff;
    logic [7:0] pend_addr_ff;
    logic [15:0] baud_ff;
    logic mb_hit;
    logic [31:0] mb_val;

    // Answer primary address 1 or the serial as secondary
    assign mb_hit = (mb_primary == fmrd_pkg::MB_PRIMARY_ADDR) || (mb_secondary == SERIAL_BCD);
    // Value register map
    assign mb_val = (pend_addr_ff == fmrd_pkg::MB_ADDR_CONSUMPTION) ? consumption_in
                  : (pend_addr_ff == fmrd_pkg::MB_ADDR_FLOW) ? flow_in
                  : (pend_addr_ff == fmrd_pkg::MB_ADDR_STATUS) ? link_status_in : 32'h0000_0000;

    // Bit rate enable for the serial engine
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baud_ff <= 16'h0000;
            mb_bit_tick <= 1'b0;
        end else begin
            mb_bit_tick <= baud_ff == 16'(fmrd_pkg::MB_BIT_CYCLES - 1);
            baud_ff <= (baud_ff == 16'(fmrd_pkg::MB_BIT_CYCLES - 1)) ? 16'h0000 : baud_ff + 16'h0001;
        end
    end

    // Response delay, response timeout and receive abort
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dly_ff <= 32'h0000_0000;
            tmo_ff <= 32'h0000_0000;
            rxt_ff <= 32'h0000_0000;
            pend_ff <= 1'b0;
            pend_addr_ff <= 8'h00;
            mb_resp_valid <= 1'b0;
            mb_resp_data <= 32'h0000_0000;
            mb_resp_timeout <= 1'b0;
            mb_rx_abort <= 1'b0;
        end else begin
            mb_resp_valid <= 1'b0;
            mb_resp_timeout <= 1'b0;
            mb_rx_abort <= 1'b0;
            if (!pend_ff && mb_req && mb_hit) begin
                pend_ff <= 1'b1;
                pend_addr_ff <= mb_value_addr;
                dly_ff <= 32'h0000_0000;
            end else if (pend_ff) begin
                dly_ff <= dly_ff + 32'h0000_0001;
                if (dly_ff == 32'(RESP_DELAY - 1)) begin
                    pend_ff <= 1'b0;
                    mb_resp_valid <= 1'b1;
                    mb_resp_data <= mb_val;
                end
            end
            // Time-out counted from the last request seen; an answer cancels it
            if (mb_req) begin
                tmo_ff <= 32'(RESP_TIMEOUT);
            end else if (mb_resp_valid) begin
                tmo_ff <= 32'h0000_0000;
            end else if (tmo_ff != 32'h0000_0000) begin
                tmo_ff <= tmo_ff - 32'h0000_0001;
                mb_resp_timeout <= (tmo_ff == 32'h0000_0001) & !mb_resp_valid;
            end
            rxt_ff <= mb_rx_active ? rxt_ff + 32'h0000_0001 : 32'h0000_0000;
            mb_rx_abort <= mb_rx_active && rxt_ff == 32'(RECV_TIMEOUT - 1);
        end
    end

    fmrd_logger #(
        .DEPTH(LOG_DEPTH)
    ) u_logger (
        .clock(clock),
        .rst_b(rst_b),
        .log_enable(log_enable),
        .sample_tick(sample_tick),
        .timestamp(timestamp_in),
        .flow(flow_in),
        .consumption(consumption_in),
        .pressure(pressure_in),
        .rec_we(rec_we),
        .rec_addr(rec_addr),
        .rec_data(rec_data),
        .rec_count(rec_count)
    );

    sequence s_req_taken;
        state_ff == FMRD_IDLE && rd_req && addr_ok && rd_count != 8'h00;
    endsequence
    property p_func_code;
        @(posedge clock) disable iff (!rst_b)
        s_req_taken |=> tx_valid && tx_byte == fmrd_pkg::FUNC_READ_HOLDING;
    endproperty
    a_func_code: assert property (p_func_code) else $error("bad function code");
    // First data byte of a pressure read is byte1 of the value
    sequence s_first_pressure_byte;
        state_ff == FMRD_DATA && !hi_ff && addr_ff == fmrd_pkg::REG_PRESSURE;
    endsequence
    property p_swap;
        @(posedge clock) disable iff (!rst_b)
        s_first_pressure_byte |-> tx_byte == snap_p_ff[15:8];
    endproperty
    a_swap: assert property (p_swap) else $error("byte order wrong");
    property p_pressure_map;
        @(posedge clock) disable iff (!rst_b)
        (addr_ff == fmrd_pkg::REG_PRESSURE) |-> cur_word == {1'b1, snap_p_ff[15:0]};
    endproperty
    a_pressure_map: assert property (p_pressure_map) else $error("pressure map");
    property p_delay;
        @(posedge clock) disable iff (!rst_b)
        $rose(pend_ff) |-> !mb_resp_valid [*8];
    endproperty
    a_delay: assert property (p_delay) else $error("answered too early");
    property p_abort;
        @(posedge clock) disable iff (!rst_b)
        mb_rx_abort |-> $past(rxt_ff) == 32'(RECV_TIMEOUT - 1);
    endproperty
    a_abort: assert property (p_abort) else $error("receive abort off");
    property p_hit;
        @(posedge clock) disable iff (!rst_b)
        (!pend_ff && mb_req && !mb_hit) |=> !pend_ff;
    endproperty
    a_hit: assert property (p_hit) else $error("answered wrong address");
    property p_status;
        @(posedge clock) disable iff (!rst_b)
        (mb_resp_valid && $past(pend_addr_ff) == fmrd_pkg::MB_ADDR_STATUS)
        |-> mb_resp_data == $past(link_status_in);
    endproperty
    a_status: assert property (p_status) else $error("status register wrong");
    property p_ro;
        @(posedge clock) disable iff (!rst_b)
        (state_ff != FMRD_IDLE) |=> $stable(snap_f_ff);
    endproperty
    a_ro: assert property (p_ro) else $error("snapshot changed mid read");
endmodule
`default_nettype wire

/* File: dv/fmrd_master_model.sv */
// Polling master model: takes response bytes, rebuilds host orders
`timescale 1ns/1ps
`default_nettype none
module fmrd_master_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Response byte stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    output logic tx_ready,
    // Bench control and results
    input wire logic clr,
    input wire logic slow,
    output logic [7:0] hdr_ff,
    output logic [7:0] cnt_ff,
    output logic last_ff,
    output logic [31:0] be_word,
    output logic [31:0] le_word
);
    logic [31:0] w_ff;
    logic tog_ff;
    // Slow mode stalls every other cycle
    assign tx_ready = !slow || tog_ff;
    // Wire order b1 b0 b3 b2 rebuilt for each host order
    assign be_word = {w_ff[15:0], w_ff[31:16]};
    assign le_word = {w_ff[23:16], w_ff[31:24], w_ff[7:0], w_ff[15:8]};
    // Byte capture; first byte of a frame is the function code
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hdr_ff <= 8'h00;
            cnt_ff <= 8'h00;
            last_ff <= 1'b0;
            w_ff <= 32'h0;
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= !tog_ff;
            if (clr) begin
                cnt_ff <= 8'h00;
                last_ff <= 1'b0;
            end else if (tx_valid && tx_ready) begin
                cnt_ff <= cnt_ff + 8'h01;
                last_ff <= tx_last;
                if (cnt_ff == 8'h00) hdr_ff <= tx_byte;
                else w_ff <= {w_ff[23:0], tx_byte};
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_flow_meter_fieldbus_readout.sv */
// Self-checking bench for the flow meter readout block
`timescale 1ns/1ps
`default_nettype none
module tb_flow_meter_fieldbus_readout;
    localparam int RD = 20;
    localparam int RT = 40;
    localparam int RV = 60;
    // Serial number value is arbitrary
    localparam logic [31:0] SER = 32'h1234_5678;
    localparam logic [31:0] PR = 32'h3F9D_70A4;
    localparam logic [31:0] FL = 32'h4248_CCCD;
    localparam logic [31:0] CO = 32'h0001_E240;
    localparam logic [31:0] ST = 32'h0000_00A5;
    logic clock, rst_b, rd_req, rd_busy, tx_valid, tx_last, tx_ready, mb_req, mb_rx_active;
    logic mb_resp_valid, mb_resp_timeout, mb_rx_abort, mb_bit_tick, log_enable, sample_tick;
    logic rec_we, clr, slow, last_ff;
    logic [31:0] ts, mb_secondary, mb_resp_data, be_word, le_word;
    logic [15:0] rd_addr;
    logic [7:0] rd_count, tx_byte, mb_primary, mb_value_addr, hdr_ff, cnt_ff;
    logic [22:0] rec_addr, rec_count;
    logic [127:0] rec_data;
    int errors, checked, cyc;

    // One meter on this link
    fmrd_top #(.RESP_DELAY(RD), .RESP_TIMEOUT(RT), .RECV_TIMEOUT(RV), .LOG_DEPTH(8),
        .SERIAL_BCD(SER)) fmrd_top_i (.clock(clock), .rst_b(rst_b), .flow_in(FL),
        .consumption_in(CO), .pressure_in(PR), .link_status_in(ST), .timestamp_in(ts),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_count(rd_count), .rd_busy(rd_busy),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
        .mb_req(mb_req), .mb_primary(mb_primary), .mb_secondary(mb_secondary),
        .mb_value_addr(mb_value_addr), .mb_rx_active(mb_rx_active),
        .mb_resp_valid(mb_resp_valid), .mb_resp_data(mb_resp_data),
        .mb_resp_timeout(mb_resp_timeout), .mb_rx_abort(mb_rx_abort),
        .mb_bit_tick(mb_bit_tick), .log_enable(log_enable), .sample_tick(sample_tick),
        .rec_we(rec_we), .rec_addr(rec_addr), .rec_data(rec_data), .rec_count(rec_count));
    fmrd_master_model fmrd_master_model_i (.clock(clock), .rst_b(rst_b),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
        .clr(clr), .slow(slow), .hdr_ff(hdr_ff), .cnt_ff(cnt_ff), .last_ff(last_ff),
        .be_word(be_word), .le_word(le_word));

    // 20 MHz clock
    always #25 clock = ~clock;

    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Hang guard, well above the tick period scenario
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            finish_test();
        end
    end

    // Register read; a second request lands mid-transfer when dup is set
    task automatic t_read(input logic [15:0] a, input logic [7:0] n, input logic sl,
        input logic dup);
        @(posedge clock);
        rd_req <= 1'b1;
        rd_addr <= a;
        rd_count <= n;
        clr <= 1'b1;
        slow <= sl;
        @(posedge clock);
        rd_req <= 1'b0;
        clr <= 1'b0;
        @(posedge clock);
        chk(rd_busy, 1'b1);
        repeat (2) @(posedge clock);
        rd_req <= dup;
        rd_addr <= 16'h0006;
        @(posedge clock);
        rd_req <= 1'b0;
        for (int i = 0; i < 100 && rd_busy !== 1'b0; i++) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask

    task automatic t_channels();
        logic [15:0] ad[3] = '{16'h0002, 16'h0006, 16'h0008};
        logic [31:0] v[3] = '{PR, FL, CO};
        for (int i = 0; i < 3; i++) begin
            t_read(ad[i], 8'h02, i == 1, i == 0);
            chk(hdr_ff, fmrd_pkg::FUNC_READ_HOLDING);
            chk(cnt_ff, 8'h05);
            chk(be_word, v[i]);
            chk(le_word, {v[i][7:0], v[i][15:8], v[i][23:16], v[i][31:24]});
            chk(last_ff, 1'b1);
        end
        t_read(16'h0006, 8'h04, 1'b0, 1'b0);
        chk(cnt_ff, 8'h09);
        chk(be_word, CO);
        t_read(16'h0004, 8'h02, 1'b0, 1'b0);
        chk(hdr_ff, fmrd_pkg::FUNC_EXCEPTION);
        chk(cnt_ff, 8'h01);
        chk(last_ff, 1'b0);
        t_read(16'h0002, 8'h00, 1'b1, 1'b0);
        chk(cnt_ff, 8'h01);
    endtask

    // Link request; ok says whether an answer is due
    task automatic t_mb(input logic [7:0] p, input logic [31:0] s, input logic [7:0] va,
        input logic ok, input logic [31:0] ex);
        int n = 0;
        int t = 0;
        logic [31:0] d = 32'h0;
        @(posedge clock);
        mb_req <= 1'b1;
        mb_primary <= p;
        mb_secondary <= s;
        mb_value_addr <= va;
        @(posedge clock);
        mb_req <= 1'b0;
        for (int i = 1; i <= RT + 4; i++) begin
            @(posedge clock);
            if (mb_resp_valid === 1'b1) n = i;
            if (mb_resp_valid === 1'b1) d = mb_resp_data;
            if (mb_resp_timeout === 1'b1) t = i;
        end
        if (ok) begin
            chk(n >= RD && n <= RD + 2, 1'b1);
            chk(d, ex);
            chk(t, 0);
        end else begin
            chk(n, 0);
            chk(t >= RT - 1 && t <= RT + 2, 1'b1);
        end
    endtask

    task automatic t_link();
        int n = 0;
        t_mb(8'h01, 32'h0, 8'h01, 1'b1, CO);
        t_mb(8'h01, 32'h0, 8'h02, 1'b1, FL);
        t_mb(8'h01, 32'h0, 8'h03, 1'b1, ST);
        t_mb(8'h01, 32'h0, 8'h04, 1'b1, 32'h0);
        t_mb(8'h07, SER, 8'h02, 1'b1, FL);
        t_mb(8'h07, 32'h0, 8'h01, 1'b0, 32'h0);
        // Reception held open until abandoned
        mb_rx_active <= 1'b1;
        for (int i = 1; i <= RV + 4 && n == 0; i++) begin
            @(posedge clock);
            if (mb_rx_abort === 1'b1) n = i;
        end
        mb_rx_active <= 1'b0;
        chk(n >= RV - 1 && n <= RV + 2, 1'b1);
        // Bit period between two ticks
        for (int i = 0; i < 9000 && mb_bit_tick !== 1'b1; i++) @(posedge clock);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (mb_bit_tick !== 1'b1 && n < 9000);
        chk(n, fmrd_pkg::MB_BIT_CYCLES);
    endtask

    // One sample tick; rec_we is looked at the cycle after the take
    task automatic t_tick(input logic [31:0] v, input logic we, input logic [22:0] ad);
        @(posedge clock);
        sample_tick <= 1'b1;
        ts <= v;
        @(posedge clock);
        sample_tick <= 1'b0;
        @(posedge clock);
        chk(rec_we, we);
        if (we) chk(rec_addr, ad);
        if (we) chk(rec_data === {v, FL, CO, PR}, 1'b1);
    endtask

    task automatic t_log();
        t_tick(32'hA000_0000, 1'b0, 23'h0);
        log_enable <= 1'b1;
        for (int k = 0; k < 10; k++) t_tick(32'hB000_0000 + k, 1'b1, 23'(k % 8));
        chk(rec_count, 23'h8);
        log_enable <= 1'b0;
        t_tick(32'hC000_0000, 1'b0, 23'h0);
    endtask

    initial begin
        {clock, rst_b, rd_req, mb_req, mb_rx_active, log_enable, sample_tick, clr, slow} = '0;
        {ts, mb_secondary, rd_addr, rd_count, mb_primary, mb_value_addr} = '0;
        {errors, checked, cyc} = '0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_log();
        t_channels();
        t_link();
        finish_test();
    end
endmodule
`default_nettype wire
